// ===== hdl/bpq_top.sv
/*
 Breakpoint compare qualifier: AXI4-Lite registers, mode forcing and the two
 comparators with registered match outputs.
 Assumes CPU cycle signals come from logic on i_mclk and a master that keeps
 at most one write and one read under way.
*/
`timescale 1ns/1ps
`default_nettype none
module bpq_top (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst,
	// AXI4-Lite write channels
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [7:0] i_awaddr,
	input wire logic i_wvalid,
	output logic o_wready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	output logic o_bvalid,
	input wire logic i_bready,
	output logic [1:0] o_bresp,
	// AXI4-Lite read channels
	input wire logic i_arvalid,
	output logic o_arready,
	input wire logic [7:0] i_araddr,
	output logic o_rvalid,
	input wire logic i_rready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	// CPU cycle
	input wire logic i_cpu_valid,
	input wire logic [15:0] i_cpu_addr,
	input wire logic [15:0] i_cpu_data,
	input wire logic [5:0] i_program_page_index,
	input wire logic i_page_sel,
	input wire logic i_cpu_rw,
	// Results
	output logic o_match_a,
	output logic o_match_b,
	output logic o_breakpoint_mode
);
	typedef struct packed {
		logic [7:0] qual;
		logic [1:0] mode;
		logic [21:0] cmpa;
		logic [21:0] cmpb;
		logic aw_got;
		logic [7:0] awaddr;
		logic w_got;
		logic [23:0] wdata;
		logic [2:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic match_a;
		logic match_b;
	} bpq_state_type;

	bpq_state_type s_q, s_d;
	logic bk_en, full, a_hit, b_hit, d_hit, dir_b_en;
	logic [1:0] mask_a, mask_b;

	assign bk_en = s_q.mode[bpq_pkg::BK_EN_POS];
	assign full = s_q.mode[bpq_pkg::FULL_POS];
	assign mask_a = bk_en ? s_q.qual[bpq_pkg::MASK_A_POS +: 2] : 2'h0;
	assign mask_b = s_q.qual[bpq_pkg::MASK_B_POS +: 2];
	assign dir_b_en = !full && s_q.qual[bpq_pkg::DIR_B_EN_POS];

	// Comparator A address match
	// Masked address compare A
	bpq_addr_cmp u_cmp_a (
		.i_mask(mask_a),
		.i_ext(s_q.cmpa[bpq_pkg::EXT_POS +: 6]),
		.i_high(s_q.cmpa[bpq_pkg::HIGH_POS +: 8]),
		.i_low(s_q.cmpa[bpq_pkg::LOW_POS +: 8]),
		.i_dir_en(s_q.qual[bpq_pkg::DIR_A_EN_POS]),
		.i_dir_val(s_q.qual[bpq_pkg::DIR_A_VAL_POS]),
		.i_valid(i_cpu_valid),
		.i_addr(i_cpu_addr),
		.i_page(i_program_page_index),
		.i_page_sel(i_page_sel),
		.i_rw(i_cpu_rw),
		.o_match(a_hit)
	);

	// Comparator B address match
	// Masked address compare B
	bpq_addr_cmp u_cmp_b (
		.i_mask(mask_b),
		.i_ext(s_q.cmpb[bpq_pkg::EXT_POS +: 6]),
		.i_high(s_q.cmpb[bpq_pkg::HIGH_POS +: 8]),
		.i_low(s_q.cmpb[bpq_pkg::LOW_POS +: 8]),
		.i_dir_en(dir_b_en),
		.i_dir_val(s_q.qual[bpq_pkg::DIR_B_VAL_POS]),
		.i_valid(i_cpu_valid),
		.i_addr(i_cpu_addr),
		.i_page(i_program_page_index),
		.i_page_sel(i_page_sel),
		.i_rw(i_cpu_rw),
		.o_match(b_hit)
	);

	// Comparator B as data match
	// Data bytes in full mode
	bpq_data_cmp u_cmp_d (
		.i_mask(mask_b),
		.i_high(s_q.cmpb[bpq_pkg::HIGH_POS +: 8]),
		.i_low(s_q.cmpb[bpq_pkg::LOW_POS +: 8]),
		.i_valid(i_cpu_valid),
		.i_data(i_cpu_data),
		.o_match(d_hit)
	);

	// Next state: bus slave, registers, matches
	always_comb begin
		logic [7:0] wa;
		logic [23:0] m;
		wa = s_q.awaddr;
		m = {{8{s_q.wstrb[2]}}, {8{s_q.wstrb[1]}}, {8{s_q.wstrb[0]}}};
		s_d = s_q;
		if (i_awvalid && !s_q.aw_got) begin
			s_d.aw_got = 1'b1;
			s_d.awaddr = i_awaddr;
		end
		if (i_wvalid && !s_q.w_got) begin
			s_d.w_got = 1'b1;
			s_d.wdata = i_wdata[23:0];
			s_d.wstrb = i_wstrb[2:0];
		end
		if (s_q.bvalid && i_bready) begin
			s_d.bvalid = 1'b0;
		end
		// Write once both halves are held
		if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
			s_d.aw_got = 1'b0;
			s_d.w_got = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = bpq_pkg::RESP_OKAY;
			unique case (wa)
				bpq_pkg::QUAL_OFS: begin
					if (s_q.wstrb[0]) begin
						s_d.qual = s_q.wdata[7:0];
					end
				end
				bpq_pkg::MODE_OFS: begin
					if (s_q.wstrb[0]) begin
						s_d.mode = s_q.wdata[1:0];
					end
				end
				bpq_pkg::CMPA_OFS: s_d.cmpa = (s_q.cmpa & ~m[21:0]) | (s_q.wdata[21:0] & m[21:0]);
				bpq_pkg::CMPB_OFS: s_d.cmpb = (s_q.cmpb & ~m[21:0]) | (s_q.wdata[21:0] & m[21:0]);
				bpq_pkg::STAT_OFS: s_d.bresp = bpq_pkg::RESP_OKAY;
				default: s_d.bresp = bpq_pkg::RESP_SLVERR;
			endcase
		end
		if (s_q.rvalid && i_rready) begin
			s_d.rvalid = 1'b0;
		end
		// Read answered one cycle after address
		if (i_arvalid && !s_q.rvalid) begin
			s_d.rvalid = 1'b1;
			s_d.rresp = bpq_pkg::RESP_OKAY;
			unique case (i_araddr)
				bpq_pkg::QUAL_OFS: s_d.rdata = {24'h000000, s_q.qual};
				bpq_pkg::MODE_OFS: s_d.rdata = {30'h00000000, s_q.mode};
				bpq_pkg::CMPA_OFS: s_d.rdata = {10'h000, s_q.cmpa};
				bpq_pkg::CMPB_OFS: s_d.rdata = {10'h000, s_q.cmpb};
				bpq_pkg::STAT_OFS: s_d.rdata = {29'h00000000, bk_en, s_q.match_b, s_q.match_a};
				default: begin
					s_d.rdata = 32'h00000000;
					s_d.rresp = bpq_pkg::RESP_SLVERR;
				end
			endcase
		end
		// Full mode joins address A and data
		s_d.match_a = a_hit && (!full || d_hit);
		// B match in dual mode only
		s_d.match_b = !full && b_hit;
		if (i_rst) begin
			s_d = '0;
			s_d.qual = bpq_pkg::QUAL_RST;
			s_d.mode = bpq_pkg::MODE_RST;
			s_d.cmpa = bpq_pkg::CMP_RST;
			s_d.cmpb = bpq_pkg::CMP_RST;
		end
	end

	// State register
	always_ff @(posedge i_mclk) begin
		s_q <= s_d;
	end

	// Bus handshakes and outputs
	assign o_awready = !s_q.aw_got;
	assign o_wready = !s_q.w_got;
	assign o_bvalid = s_q.bvalid;
	assign o_bresp = s_q.bresp;
	assign o_arready = !s_q.rvalid;
	assign o_rvalid = s_q.rvalid;
	assign o_rdata = s_q.rdata;
	assign o_rresp = s_q.rresp;
	assign o_match_a = s_q.match_a;
	assign o_match_b = s_q.match_b;
	assign o_breakpoint_mode = bk_en;

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_rst);

	// Checks on the qualification logic, its reset and the write answer hold
	chk_trace_mask_forced: assert property (!bk_en && i_cpu_valid && (i_cpu_addr[7:0] != s_q.cmpa[7:0])
		|=> !o_match_a) else $error("trace mode did not force first mask");
	chk_low_byte_skip: assert property (bk_en && !full && (s_q.qual[7:6] == 2'h1) && !s_q.qual[3]
		&& i_cpu_valid && !i_page_sel && (i_cpu_addr[15:8] == s_q.cmpa[15:8]) |=> o_match_a)
		else $error("256-byte range did not hit");
	chk_page_only_a: assert property (bk_en && (s_q.qual[7:6] == 2'h3) && !i_page_sel
		|=> !o_match_a) else $error("page-only code hit unpaged access");
	chk_half_code_full: assert property (bk_en && (s_q.qual[7:6] == 2'h2) && !i_page_sel
		&& (i_cpu_addr[15:8] != s_q.cmpa[15:8]) |=> !o_match_a) else $error("code 1:0 skipped high byte");
	chk_dir_a_qual: assert property (s_q.qual[3] && i_cpu_valid && (i_cpu_rw != s_q.qual[2])
		|=> !o_match_a) else $error("comparator A ignored direction");
	chk_full_no_b: assert property (full |=> !o_match_b) else $error("B address hit in full mode");
	chk_data_high: assert property (full && (s_q.qual[5:4] == 2'h1) && (i_cpu_data[15:8] != s_q.cmpb[15:8])
		|=> !o_match_a) else $error("data high byte not compared");
	chk_dir_b_qual: assert property (!full && s_q.qual[1] && i_cpu_valid && (i_cpu_rw != s_q.qual[0])
		|=> !o_match_b) else $error("comparator B ignored direction");
	chk_page_ext_b: assert property (!full && (s_q.qual[5:4] == 2'h3) && i_page_sel
		&& (i_program_page_index != s_q.cmpb[21:16]) |=> !o_match_b) else $error("B page-only missed ext compare");
	chk_ctl_reset: assert property (@(posedge i_mclk) disable iff (1'b0) i_rst |=> (s_q.qual == bpq_pkg::QUAL_RST))
		else $error("control not cleared by reset");
	chk_bresp_hold: assert property (o_bvalid && !i_bready |=> o_bvalid) else $error("write answer dropped");

	// Main scenarios
	cov_full_hit: cover property (full && o_match_a);
	cov_page_only: cover property (bk_en && (s_q.qual[7:6] == 2'h3) && o_match_a);
	cov_dual_b: cover property (!full && o_match_b);
endmodule // bpq_top
`default_nettype wire

// ===== hdl/bpq_pkg.sv
/*
 Constants for the breakpoint compare qualifier: register map, field positions,
 reset values and bus response codes.
 Assumes a 32-bit AXI4-Lite register bus and a 16-bit CPU address and data bus.
*/
package bpq_pkg;
	// Register byte offsets
	localparam logic [7:0] QUAL_OFS = 8'h00;
	localparam logic [7:0] MODE_OFS = 8'h04;
	localparam logic [7:0] CMPA_OFS = 8'h08;
	localparam logic [7:0] CMPB_OFS = 8'h0C;
	localparam logic [7:0] STAT_OFS = 8'h10;
	// Qualify control fields
	localparam int MASK_A_POS = 6;
	localparam int MASK_B_POS = 4;
	localparam int DIR_A_EN_POS = 3;
	localparam int DIR_A_VAL_POS = 2;
	localparam int DIR_B_EN_POS = 1;
	localparam int DIR_B_VAL_POS = 0;
	// Mode control fields
	localparam int BK_EN_POS = 1;
	localparam int FULL_POS = 0;
	// Comparator register fields
	localparam int EXT_POS = 16;
	localparam int HIGH_POS = 8;
	localparam int LOW_POS = 0;
	// Values after reset
	localparam logic [7:0] QUAL_RST = 8'h00;
	localparam logic [1:0] MODE_RST = 2'h0;
	localparam logic [21:0] CMP_RST = 22'h000000;
	// Bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== hdl/bpq_addr_cmp.sv
/*
 One address comparator with byte masking, program page extension and
 read/write qualification. Purely combinational.
 Assumes the caller has already applied mode forcing to the mask and enable.
*/
`timescale 1ns/1ps
`default_nettype none
module bpq_addr_cmp (
	// Compare setup
	input wire logic [1:0] i_mask,
	input wire logic [5:0] i_ext,
	input wire logic [7:0] i_high,
	input wire logic [7:0] i_low,
	input wire logic i_dir_en,
	input wire logic i_dir_val,
	// CPU cycle
	input wire logic i_valid,
	input wire logic [15:0] i_addr,
	input wire logic [5:0] i_page,
	input wire logic i_page_sel,
	input wire logic i_rw,
	// Result
	output logic o_match
);
	logic cmp_low, cmp_high, page_only, ext_ok, high_ok, low_ok, dir_ok;
	assign cmp_low = !i_mask[0];
	assign cmp_high = !(i_mask[1] && i_mask[0]);
	assign page_only = i_mask[1] && i_mask[0];
	assign ext_ok = !i_page_sel || (i_ext == i_page);
	assign high_ok = !cmp_high || (i_page_sel ? (i_high[5:0] == i_addr[13:8]) : (i_high == i_addr[15:8]));
	assign low_ok = !cmp_low || (i_low == i_addr[7:0]);
	assign dir_ok = !i_dir_en || (i_rw == i_dir_val);
	// Final address hit
	assign o_match = i_valid && ext_ok && high_ok && low_ok && dir_ok && (!page_only || i_page_sel);
endmodule // bpq_addr_cmp
`default_nettype wire

// ===== hdl/bpq_data_cmp.sv
/*
 Data comparator used in full mode, with per-byte masking.
 Assumes the data bus is valid whenever the cycle valid is high.
*/
`timescale 1ns/1ps
`default_nettype none
module bpq_data_cmp (
	// Compare setup
	input wire logic [1:0] i_mask,
	input wire logic [7:0] i_high,
	input wire logic [7:0] i_low,
	// CPU cycle
	input wire logic i_valid,
	input wire logic [15:0] i_data,
	// Result
	output logic o_match
);
	assign o_match = i_valid && (i_mask[1] || (i_data[15:8] == i_high)) && (i_mask[0] || (i_data[7:0] == i_low));
endmodule // bpq_data_cmp
`default_nettype wire

// ===== verif/bpq_cpu_model.sv
/*
 CPU core model: presents one bus cycle at a time on address, data, page
 and direction lines for the breakpoint compare qualifier.
 Assumes the caller invokes its tasks right after a rising edge of i_mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module bpq_cpu_model (
	// Clock
	input wire logic i_mclk,
	// CPU cycle
	output logic o_cpu_valid,
	output logic [15:0] o_cpu_addr,
	output logic [15:0] o_cpu_data,
	output logic [5:0] o_page,
	output logic o_page_sel,
	output logic o_cpu_rw
);
	// Quiet bus at start
	initial begin
		o_cpu_valid = 1'b0;
		o_cpu_addr = 16'h0000;
		o_cpu_data = 16'h0000;
		o_page = 6'h00;
		o_page_sel = 1'b0;
		o_cpu_rw = 1'b0;
	end
	// Drive one cycle
	task automatic present(input logic [15:0] a, input logic [15:0] d, input logic [5:0] p,
		input logic s, input logic rw);
		o_cpu_valid <= 1'b1;
		o_cpu_addr <= a;
		o_cpu_data <= d;
		o_page <= p;
		o_page_sel <= s;
		o_cpu_rw <= rw;
	endtask
	// Idle bus shows inverted stale values, never a held copy
	task automatic idle();
		o_cpu_valid <= 1'b0;
		o_cpu_addr <= ~o_cpu_addr;
		o_cpu_data <= ~o_cpu_data;
		o_page <= ~o_page;
		o_page_sel <= ~o_page_sel;
		o_cpu_rw <= ~o_cpu_rw;
	endtask
endmodule // bpq_cpu_model
`default_nettype wire

// ===== verif/tb_top.sv
/*
 Self-checking bench for the breakpoint compare qualifier.
 Assumes the AXI4-Lite timing and register map of the design hand-over.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_errors++; \
	$display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module tb_top;
	logic i_mclk = 1'b0, i_rst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h00000000, rdata;
	logic [1:0] bresp, rresp;
	logic valid, page_sel, rw, match_a, match_b, bk_mode;
	logic [15:0] addr, data;
	logic [5:0] page;
	int n_errors = 0, check_count = 0;
	// 40 MHz clock
	always #12.5 i_mclk = ~i_mclk;
	bpq_cpu_model u_bpq_cpu_model (.i_mclk(i_mclk), .o_cpu_valid(valid), .o_cpu_addr(addr),
		.o_cpu_data(data), .o_page(page), .o_page_sel(page_sel), .o_cpu_rw(rw));
	bpq_top u_bpq_top (.i_mclk(i_mclk), .i_rst(i_rst), .i_awvalid(awvalid), .o_awready(awready),
		.i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata), .i_wstrb(4'hF),
		.o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp), .i_arvalid(arvalid),
		.o_arready(arready), .i_araddr(araddr), .o_rvalid(rvalid), .i_rready(rready),
		.o_rdata(rdata), .o_rresp(rresp), .i_cpu_valid(valid), .i_cpu_addr(addr),
		.i_cpu_data(data), .i_program_page_index(page), .i_page_sel(page_sel), .i_cpu_rw(rw),
		.o_match_a(match_a), .o_match_b(match_b), .o_breakpoint_mode(bk_mode));
	// Verdict and stop
	task automatic end_of_test;
		$display("Errors %0d of %0d checks", n_errors, check_count);
		if (n_errors == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Write; ready sampled at negedge is the value seen at the next edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ah, wh, bh, done;
		logic [1:0] r;
		done = 1'b0;
		@(posedge i_mclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int n = 0; n < 50 && !done; n++) begin
			@(negedge i_mclk);
			ah = awvalid && awready;
			wh = wvalid && wready;
			bh = bready && bvalid;
			r = bresp;
			@(posedge i_mclk);
			if (ah) awvalid <= 1'b0;
			if (wh) wvalid <= 1'b0;
			if (bh) begin
				bready <= 1'b0;
				done = 1'b1;
			end
		end
		if (!done) begin
			n_errors++;
			end_of_test();
		end
		`CHK("bresp", er, r)
	endtask
	// Read and compare
	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic ah, rh, done;
		logic [31:0] d;
		logic [1:0] r;
		done = 1'b0;
		@(posedge i_mclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int n = 0; n < 50 && !done; n++) begin
			@(negedge i_mclk);
			ah = arvalid && arready;
			rh = rready && rvalid;
			d = rdata;
			r = rresp;
			@(posedge i_mclk);
			if (ah) arvalid <= 1'b0;
			if (rh) begin
				rready <= 1'b0;
				done = 1'b1;
			end
		end
		if (!done) begin
			n_errors++;
			end_of_test();
		end
		`CHK("rdata", ed, d)
		`CHK("rresp", er, r)
	endtask
	// Qualify control write
	task automatic q(input logic [7:0] v);
		wr(bpq_pkg::QUAL_OFS, {24'h000000, v}, bpq_pkg::RESP_OKAY);
	endtask
	// One CPU cycle; match shows one clock later
	task automatic cyc(input logic [15:0] a, input logic [15:0] d, input logic [5:0] p,
		input logic s, input logic r, input logic ea, input logic eb);
		@(posedge i_mclk);
		u_bpq_cpu_model.present(a, d, p, s, r);
		@(posedge i_mclk);
		u_bpq_cpu_model.idle();
		@(negedge i_mclk);
		`CHK("match_a", ea, match_a)
		`CHK("match_b", eb, match_b)
	endtask
	// Reset values, unmapped place, comparator setup
	task automatic t_regs;
		rd(bpq_pkg::QUAL_OFS, 32'h00000000, bpq_pkg::RESP_OKAY);
		rd(8'h14, 32'h00000000, bpq_pkg::RESP_SLVERR);
		wr(8'h14, 32'h000000FF, bpq_pkg::RESP_SLVERR);
		q(8'hFF);
		rd(bpq_pkg::QUAL_OFS, 32'h000000FF, bpq_pkg::RESP_OKAY);
		q(8'h00);
		wr(bpq_pkg::CMPA_OFS, 32'h002A1234, bpq_pkg::RESP_OKAY);
		wr(bpq_pkg::CMPB_OFS, 32'h00155678, bpq_pkg::RESP_OKAY);
		wr(bpq_pkg::MODE_OFS, 32'h00000002, bpq_pkg::RESP_OKAY);
		@(negedge i_mclk);
		`CHK("bk_mode", 1'b1, bk_mode)
	endtask
	// Dual mode address compares and masks
	task automatic t_dual;
		cyc(16'h1234, 16'h0000, 6'h00, 1'b0, 1'b1, 1'b1, 1'b0);
		cyc(16'h1235, 16'h0000, 6'h00, 1'b0, 1'b1, 1'b0, 1'b0);
		cyc(16'hD234, 16'h0000, 6'h2A, 1'b1, 1'b1, 1'b1, 1'b0);
		cyc(16'hD234, 16'h0000, 6'h2B, 1'b1, 1'b1, 1'b0, 1'b0);
		cyc(16'h5678, 16'h0000, 6'h00, 1'b0, 1'b0, 1'b0, 1'b1);
		q(8'h40);
		cyc(16'h12FF, 16'h0000, 6'h00, 1'b0, 1'b1, 1'b1, 1'b0);
		q(8'h80);
		cyc(16'h12FF, 16'h0000, 6'h00, 1'b0, 1'b1, 1'b0, 1'b0);
		q(8'hC0);
		cyc(16'h1234, 16'h0000, 6'h00, 1'b0, 1'b1, 1'b0, 1'b0);
		cyc(16'h0000, 16'h0000, 6'h2A, 1'b1, 1'b1, 1'b1, 1'b0);
		q(8'h10);
		cyc(16'h56AA, 16'h0000, 6'h00, 1'b0, 1'b1, 1'b0, 1'b1);
		q(8'h20);
		cyc(16'h56AA, 16'h0000, 6'h00, 1'b0, 1'b1, 1'b0, 1'b0);
		q(8'h30);
		cyc(16'h0000, 16'h0000, 6'h15, 1'b1, 1'b1, 1'b0, 1'b1);
	endtask
	// Direction qualification
	task automatic t_dir;
		q(8'h08);
		cyc(16'h1234, 16'h0000, 6'h00, 1'b0, 1'b1, 1'b0, 1'b0);
		cyc(16'h1234, 16'h0000, 6'h00, 1'b0, 1'b0, 1'b1, 1'b0);
		q(8'h04);
		cyc(16'h1234, 16'h0000, 6'h00, 1'b0, 1'b0, 1'b1, 1'b0);
		q(8'h03);
		cyc(16'h5678, 16'h0000, 6'h00, 1'b0, 1'b0, 1'b0, 1'b0);
		cyc(16'h5678, 16'h0000, 6'h00, 1'b0, 1'b1, 1'b0, 1'b1);
	endtask
	// Trace mode, then full mode data masks
	task automatic t_modes;
		wr(bpq_pkg::MODE_OFS, 32'h00000000, bpq_pkg::RESP_OKAY);
		q(8'h40);
		cyc(16'h12FF, 16'h0000, 6'h00, 1'b0, 1'b1, 1'b0, 1'b0);
		`CHK("bk_mode", 1'b0, bk_mode)
		wr(bpq_pkg::MODE_OFS, 32'h00000003, bpq_pkg::RESP_OKAY);
		q(8'h00);
		cyc(16'h1234, 16'h5678, 6'h00, 1'b0, 1'b1, 1'b1, 1'b0);
		cyc(16'h1234, 16'h5679, 6'h00, 1'b0, 1'b1, 1'b0, 1'b0);
		q(8'h10);
		cyc(16'h1234, 16'h56FF, 6'h00, 1'b0, 1'b1, 1'b1, 1'b0);
		q(8'h20);
		cyc(16'h1234, 16'hFF78, 6'h00, 1'b0, 1'b1, 1'b1, 1'b0);
		q(8'h30);
		cyc(16'h1234, 16'h0000, 6'h00, 1'b0, 1'b1, 1'b1, 1'b0);
		q(8'h03);
		cyc(16'h1234, 16'h5678, 6'h00, 1'b0, 1'b0, 1'b1, 1'b0);
		wr(bpq_pkg::STAT_OFS, 32'h000000FF, bpq_pkg::RESP_OKAY);
		rd(bpq_pkg::STAT_OFS, 32'h00000004, bpq_pkg::RESP_OKAY);
	endtask
	// Main sequence
	initial begin
		repeat (20) @(posedge i_mclk);
		i_rst <= 1'b0;
		t_regs();
		t_dual();
		t_dir();
		t_modes();
		end_of_test();
	end
endmodule // tb_top
`default_nettype wire
